// ===== verilog/nfh_pkg.sv
// Purpose: shared constants and types of the flash program/erase host engine
// Assumes: byte-wide multiplexed flash port, 100 MHz system clock
// Notes:   status bit positions follow the device's read-status byte
`default_nettype none
package nfh_pkg;
  localparam logic [7:0] CMD_READ          = 8'h00;
  localparam logic [7:0] CMD_SERIAL_IN     = 8'h80;
  localparam logic [7:0] CMD_RANDOM_IN     = 8'h85;
  localparam logic [7:0] CMD_PROG_CONFIRM  = 8'h10;
  localparam logic [7:0] CMD_CACHE_PROG    = 8'h15;
  localparam logic [7:0] CMD_COPY_READ     = 8'h35;
  localparam logic [7:0] CMD_ERASE_SETUP   = 8'h60;
  localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hd0;
  localparam logic [7:0] CMD_READ_STATUS   = 8'h70;
  localparam logic [7:0] CMD_SET_FEATURE   = 8'hef;
  localparam logic [7:0] FEAT_OTP_ADDR     = 8'h90;
  localparam logic [7:0] FEAT_OTP_EXIT     = 8'h00;
  localparam logic [7:0] FEAT_OTP_ENTER    = 8'h01;
  localparam logic [7:0] FEAT_OTP_PROTECT  = 8'h03;
  localparam int status_pass_fail_bit    = 0;
  localparam int status_array_ready_bit  = 5;
  localparam int status_cache_ready_bit  = 6;
  localparam int CLK_PERIOD_NS = 10;
  localparam int STROBE_NS     = 25;
  localparam int WB_NS         = 100;
  localparam int STROBE_CYC    = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WB_CYC        = (WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_STAGES   = 2;
  localparam int RD_LOW_CYC    = STROBE_CYC + SYNC_STAGES + 1;
  localparam logic [11:0] PAGE_BYTES    = 12'h840;
  localparam logic [7:0]  OTP_LAST_PAGE = 8'h1d;
  localparam int PAGE_BITS = 6;

  typedef enum logic [3:0] {
    OP_PROGRAM, OP_RANDOM_IN, OP_CONFIRM, OP_CACHE_CONFIRM, OP_COPY_READ, OP_COPY_PROGRAM,
    OP_READ_OUT, OP_ERASE, OP_OTP_ENTER, OP_OTP_EXIT, OP_OTP_PROTECT
  } nfhOp_t;

  typedef struct packed {
    nfhOp_t      op;
    logic [15:0] col;
    logic [15:0] row;
    logic [11:0] len;
  } nfhReq_t;

  typedef struct packed {
    logic       refused;
    logic       fail;
    logic [7:0] status;
  } nfhResp_t;

  typedef struct packed {
    logic       cle;
    logic       ale;
    logic       weN;
    logic       reN;
    logic       ceN;
    logic       oe;
    logic [7:0] data;
  } nfhPins_t;

  typedef struct packed {
    logic [7:0] cmd1;
    logic [2:0] nAddr;
    logic [1:0] addrBase;
    logic       feat;
    logic       write;
    logic       read;
    logic       hasCmd2;
    logic [7:0] cmd2;
    logic       busy;
  } nfhOpInfo_t;

  function automatic nfhOpInfo_t nfhDecode(input nfhOp_t op);
    nfhOpInfo_t d;
    d = '{cmd1: CMD_READ, nAddr: 3'h0, addrBase: 2'h0, feat: 1'b0, write: 1'b0, read: 1'b0,
          hasCmd2: 1'b0, cmd2: CMD_READ, busy: 1'b0};
    case (op)
      OP_PROGRAM:       begin d.cmd1 = CMD_SERIAL_IN; d.nAddr = 3'h4; d.write = 1'b1; end
      OP_RANDOM_IN:     begin d.cmd1 = CMD_RANDOM_IN; d.nAddr = 3'h2; d.write = 1'b1; end
      OP_CONFIRM:       begin d.cmd1 = CMD_PROG_CONFIRM; d.busy = 1'b1; end
      OP_CACHE_CONFIRM: begin d.cmd1 = CMD_CACHE_PROG; d.busy = 1'b1; end
      OP_COPY_READ:     begin d.nAddr = 3'h4; d.hasCmd2 = 1'b1; d.cmd2 = CMD_COPY_READ; d.busy = 1'b1; end
      OP_COPY_PROGRAM:  begin d.cmd1 = CMD_RANDOM_IN; d.nAddr = 3'h4; d.write = 1'b1; end
      OP_READ_OUT:      begin d.read = 1'b1; end
      OP_ERASE:         begin
        d.cmd1 = CMD_ERASE_SETUP; d.nAddr = 3'h2; d.addrBase = 2'h2;
        d.hasCmd2 = 1'b1; d.cmd2 = CMD_ERASE_CONFIRM; d.busy = 1'b1;
      end
      default:          begin
        d.cmd1 = CMD_SET_FEATURE; d.nAddr = 3'h1; d.feat = 1'b1; d.write = 1'b1; d.busy = 1'b1;
      end
    endcase
    return d;
  endfunction : nfhDecode
endpackage : nfh_pkg
`default_nettype wire

// ===== verilog/nfh_host.sv
// Purpose: host engine driving page program, cache/copy-back program, erase and OTP mode on a flash port
// Assumes: one request at a time; device ready/busy and data pins asynchronous to clk
// Notes:   each request is one command phase; a page program is PROGRAM [RANDOM_IN..] CONFIRM
// Functional notes
// - page program opens with serial-input command, four address bytes, then data
// - while busy only status reads are sent to the device
// - pages within one block are programmed in ascending order
// - cache sequence stays in one block and ends with normal confirm
// - copy-back program sends destination address, optional reload, then confirm
// - erase sends setup, two row bytes with page bits zero, confirm
// - in OTP mode column bytes and fourth address byte are zero
// - in OTP mode no random input, one program per page, ascending pages
`default_nettype none
module nfh_host
  import nfh_pkg::*;
#(
  parameter int FIFO_DEPTH = 2,
  parameter int FIFO_WIDTH = 8
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  // request and answer
  input  wire nfhReq_t               reqIn,
  input  wire logic                  reqValid,
  output logic                       reqReady,
  output nfhResp_t                   respOut,
  output logic                       respValid,
  // write data stream
  input  wire logic [FIFO_WIDTH-1:0] wrData,
  input  wire logic                  wrValid,
  output logic                       wrReady,
  // read data stream
  output logic [7:0]                 rdData,
  output logic                       rdValid,
  input  wire logic                  rdReady,
  // flash pins
  input  wire logic [7:0]            nandIoIn,
  output logic [7:0]                 nandIoOut,
  output logic                       nandIoOe,
  output logic                       nandCle,
  output logic                       nandAle,
  output logic                       nandWeN,
  output logic                       nandReN,
  output logic                       nandCeN,
  output logic                       nandWpN,
  input  wire logic                  nandRbN
);
  typedef enum logic [10:0] {
    ST_IDLE = 11'h001, ST_CMD = 11'h002, ST_ADDR = 11'h004, ST_WR = 11'h008, ST_RD = 11'h010,
    ST_CMD2 = 11'h020, ST_WB = 11'h040, ST_RB = 11'h080, ST_STAT_CMD = 11'h100,
    ST_STAT_RD = 11'h200, ST_DONE = 11'h400
  } nfhState_t;

  localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;

  nfhState_t stateReg, stateNext;
  nfhReq_t   reqReg;
  nfhResp_t  respReg;
  nfhPins_t  pinsReg, pinsNext;
  logic [7:0]  cntReg, cntNext;
  logic        phReg, phNext;
  logic [11:0] beatReg, beatNext;
  logic [7:0]  ioSync1, ioSync2, statusReg, wrByteReg, rdDataReg;
  logic        rbSync1, rbSync2, rdValidReg;
  logic        loadedReg, cachePendReg, otpModeReg, otpLockedReg, havePrevReg;
  logic [9:0]  lastBlockReg;
  logic [5:0]  lastPageReg;
  logic [7:0]  otpNextReg;
  logic [FIFO_WIDTH-1:0] fifoMem [FIFO_DEPTH];
  logic [PW-1:0] fifoWp, fifoRp;
  logic [PW:0]   fifoCnt;

  // request decode
  nfhOpInfo_t info, inInfo;
  assign info   = nfhDecode(reqReg.op);
  assign inInfo = nfhDecode(reqIn.op);
  wire reqFire  = reqValid && reqReady;
  wire isProg   = reqIn.op == OP_PROGRAM;
  wire [7:0] inPage = reqIn.row[7:0];
  wire sameBlock = reqIn.row[15:PAGE_BITS] == lastBlockReg;
  wire refuseData = (reqIn.op == OP_CONFIRM || reqIn.op == OP_CACHE_CONFIRM) && !loadedReg;
  wire refuseRand = reqIn.op == OP_RANDOM_IN && (!loadedReg || otpModeReg);
  wire refuseOtp  = otpModeReg && isProg
                    && (otpLockedReg || inPage < otpNextReg || inPage > OTP_LAST_PAGE);
  wire refuseSeq  = !otpModeReg && isProg && havePrevReg && sameBlock
                    && reqIn.row[PAGE_BITS-1:0] <= lastPageReg;
  wire refuseCache = cachePendReg && ((isProg && !sameBlock) || reqIn.op == OP_ERASE
                     || reqIn.op == OP_COPY_READ || reqIn.op == OP_COPY_PROGRAM || inInfo.feat);
  wire refuseLen  = inInfo.write && !inInfo.feat && reqIn.len > PAGE_BYTES;
  wire refuseAny  = refuseData || refuseRand || refuseOtp || refuseSeq || refuseCache || refuseLen;
  // taken from the captured request: the request port may already carry the next one
  wire [7:0] featVal = (reqReg.op == OP_OTP_ENTER) ? FEAT_OTP_ENTER :
                       (reqReg.op == OP_OTP_EXIT) ? FEAT_OTP_EXIT : FEAT_OTP_PROTECT;

  // sequencing helpers
  wire tick    = cntReg == 8'h00;
  wire beatEnd = phReg && tick;
  wire rdState = stateReg == ST_RD || stateReg == ST_STAT_RD;
  wire sampleNow = !phReg && tick && rdState;
  wire [7:0] lowLen = rdState ? 8'(RD_LOW_CYC - 1) : 8'(STROBE_CYC - 1);
  nfhState_t afterCmd2, afterData, afterAddr, afterCmd;
  assign afterCmd2 = info.busy ? ST_WB : ST_DONE;
  assign afterData = info.hasCmd2 ? ST_CMD2 : afterCmd2;
  assign afterAddr = info.write ? ST_WR : (info.read ? ST_RD : afterData);
  assign afterCmd  = (info.nAddr != 3'h0) ? ST_ADDR : afterAddr;
  wire fifoValid = fifoCnt != '0;
  wire fifoFull  = fifoCnt == (PW+1)'(FIFO_DEPTH);
  wire wrStart   = stateReg == ST_WR && beatEnd && beatReg < reqReg.len && (info.feat || fifoValid);
  wire fifoPop   = wrStart && !info.feat;
  wire fifoPush  = wrValid && !fifoFull;
  wire rdStart   = stateReg == ST_RD && beatEnd && beatReg < reqReg.len && (!rdValidReg || rdReady);

  // address bytes; OTP forces zero columns and high row, erase zeroes the page bits
  wire [1:0] addrSel = 2'(beatReg[1:0] - 2'h1 + info.addrBase);
  wire [7:0] rowLo = (reqReg.op == OP_ERASE) ? {reqReg.row[7:PAGE_BITS], {PAGE_BITS{1'b0}}} : reqReg.row[7:0];
  wire [7:0] addrByte = info.feat ? FEAT_OTP_ADDR :
                        (otpModeReg && (addrSel != 2'h2)) ? 8'h00 :
                        (addrSel == 2'h0) ? reqReg.col[7:0] :
                        (addrSel == 2'h1) ? reqReg.col[15:8] :
                        (addrSel == 2'h2) ? rowLo : reqReg.row[15:8];

  always_comb begin
    stateNext = stateReg;
    cntNext   = cntReg;
    phNext    = phReg;
    beatNext  = beatReg;
    if (!tick) begin
      cntNext = cntReg - 8'h01;
    end else if (!phReg) begin
      phNext  = 1'b1;
      cntNext = 8'(STROBE_CYC - 1);
    end
    case (stateReg)
      ST_IDLE:     if (reqFire) stateNext = refuseAny ? ST_DONE : ST_CMD;
      ST_CMD:      if (beatEnd && beatReg != 12'h000) stateNext = (info.cmd1 == CMD_READ && info.nAddr == 3'h0
                     && !info.read) ? afterCmd : afterCmd;
      ST_ADDR:     if (beatEnd && beatReg >= {9'h000, info.nAddr}) stateNext = afterAddr;
      ST_WR:       if (beatEnd && beatReg >= reqReg.len) stateNext = afterData;
      ST_RD:       if (beatEnd && beatReg >= reqReg.len && !rdValidReg) stateNext = afterData;
      ST_CMD2:     if (beatEnd && beatReg != 12'h000) stateNext = afterCmd2;
      ST_WB:       if (beatReg == 12'(WB_CYC)) stateNext = ST_RB;
      ST_RB:       if (rbSync2) stateNext = ST_STAT_CMD;
      ST_STAT_CMD: if (beatEnd && beatReg != 12'h000) stateNext = ST_STAT_RD;
      ST_STAT_RD:  if (beatEnd && beatReg != 12'h000 && statusReg[status_cache_ready_bit])
                     stateNext = ST_DONE;
      default:     stateNext = ST_IDLE;
    endcase
    if (stateNext != stateReg) begin
      phNext   = 1'b1;
      cntNext  = 8'h00;
      beatNext = 12'h000;
    end else if (stateReg == ST_WB) begin
      beatNext = beatReg + 12'h001;
    end else if (beatEnd && (wrStart || rdStart
                 || ((stateReg == ST_CMD || stateReg == ST_CMD2 || stateReg == ST_STAT_CMD) && beatReg == 12'h000)
                 || (stateReg == ST_ADDR && beatReg < {9'h000, info.nAddr}) || stateReg == ST_STAT_RD)) begin
      phNext   = 1'b0;
      cntNext  = lowLen;
      beatNext = beatReg + 12'h001;
    end
  end

  // pin drive, registered
  wire weState = stateReg == ST_CMD || stateReg == ST_ADDR || stateReg == ST_WR
                 || stateReg == ST_CMD2 || stateReg == ST_STAT_CMD;
  wire cleState = stateReg == ST_CMD || stateReg == ST_CMD2 || stateReg == ST_STAT_CMD;
  assign pinsNext.cle  = cleState;
  assign pinsNext.ale  = stateReg == ST_ADDR;
  assign pinsNext.weN  = !(weState && !phNext);
  assign pinsNext.reN  = !(rdState && !phNext);
  assign pinsNext.ceN  = stateReg == ST_IDLE;
  assign pinsNext.oe   = weState;
  assign pinsNext.data = (stateReg == ST_CMD) ? info.cmd1 : (stateReg == ST_CMD2) ? info.cmd2 :
                         (stateReg == ST_STAT_CMD) ? CMD_READ_STATUS :
                         (stateReg == ST_ADDR) ? addrByte : wrByteReg;

  always_ff @(posedge clk) begin
    ioSync1 <= nandIoIn;
    ioSync2 <= ioSync1;
    rbSync1 <= nandRbN;
    rbSync2 <= rbSync1;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stateReg <= ST_IDLE;
      cntReg   <= 8'h00;
      phReg    <= 1'b1;
      beatReg  <= 12'h000;
      pinsReg  <= '{cle: 1'b0, ale: 1'b0, weN: 1'b1, reN: 1'b1, ceN: 1'b1, oe: 1'b0, data: 8'h00};
    end else begin
      stateReg <= stateNext;
      cntReg   <= cntNext;
      phReg    <= phNext;
      beatReg  <= beatNext;
      pinsReg  <= pinsNext;
    end
  end

  // request capture and answer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reqReg  <= '0;
      respReg <= '0;
    end else if (reqFire) begin
      reqReg  <= reqIn;
      respReg <= '0;
      if (inInfo.feat) reqReg.len <= 12'h001;
      if (refuseAny) respReg.refused <= 1'b1;
    end else if (sampleNow && stateReg == ST_STAT_RD) begin
      respReg.status <= ioSync2;
      respReg.fail   <= ioSync2[status_pass_fail_bit];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) statusReg <= 8'h00;
    else if (stateReg == ST_STAT_CMD) statusReg <= 8'h00;
    else if (sampleNow && stateReg == ST_STAT_RD) statusReg <= ioSync2;
  end

  // load, cache and OTP bookkeeping
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      loadedReg <= 1'b0; cachePendReg <= 1'b0; otpModeReg <= 1'b0; otpLockedReg <= 1'b0;
      havePrevReg <= 1'b0; lastBlockReg <= 10'h000; lastPageReg <= 6'h00; otpNextReg <= 8'h00;
    end else if (reqFire && !refuseAny) begin
      case (reqIn.op)
        OP_PROGRAM: begin
          loadedReg    <= reqIn.len != 12'h000;
          havePrevReg  <= !otpModeReg;
          lastBlockReg <= reqIn.row[15:PAGE_BITS];
          lastPageReg  <= reqIn.row[PAGE_BITS-1:0];
          if (otpModeReg) otpNextReg <= inPage + 8'h01;
        end
        OP_RANDOM_IN:     loadedReg <= 1'b1;
        OP_COPY_PROGRAM:  loadedReg <= 1'b1;
        OP_CONFIRM:       begin loadedReg <= 1'b0; cachePendReg <= 1'b0; end
        OP_CACHE_CONFIRM: begin loadedReg <= 1'b0; cachePendReg <= 1'b1; end
        OP_OTP_ENTER:     otpModeReg <= 1'b1;
        OP_OTP_EXIT:      otpModeReg <= 1'b0;
        OP_OTP_PROTECT:   otpLockedReg <= 1'b1;
        default:          loadedReg <= loadedReg;
      endcase
    end
  end

  // two-entry write buffer; wrReady drops when full so the source stalls
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fifoWp <= '0; fifoRp <= '0; fifoCnt <= '0;
    end else begin
      if (fifoPush) fifoWp <= (fifoWp == PW'(FIFO_DEPTH - 1)) ? '0 : fifoWp + 1'b1;
      if (fifoPop) fifoRp <= (fifoRp == PW'(FIFO_DEPTH - 1)) ? '0 : fifoRp + 1'b1;
      fifoCnt <= fifoCnt + (PW+1)'(fifoPush) - (PW+1)'(fifoPop);
    end
  end
  always_ff @(posedge clk) begin
    if (fifoPush) fifoMem[fifoWp] <= wrData;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) wrByteReg <= 8'h00;
    else if (wrStart) wrByteReg <= info.feat ? featVal : 8'(fifoMem[fifoRp]);
  end

  // read stream: next read strobe waits for rdReady, so no byte is dropped
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdValidReg <= 1'b0; rdDataReg <= 8'h00;
    end else if (sampleNow && stateReg == ST_RD) begin
      rdValidReg <= 1'b1; rdDataReg <= ioSync2;
    end else if (rdReady) begin
      rdValidReg <= 1'b0;
    end
  end

  assign reqReady  = stateReg == ST_IDLE;
  assign respValid = stateReg == ST_DONE;
  assign respOut   = respReg;
  assign wrReady   = !fifoFull;
  assign rdData    = rdDataReg;
  assign rdValid   = rdValidReg;
  assign nandIoOut = pinsReg.data;
  assign nandIoOe  = pinsReg.oe;
  assign nandCle   = pinsReg.cle;
  assign nandAle   = pinsReg.ale;
  assign nandWeN   = pinsReg.weN;
  assign nandReN   = pinsReg.reN;
  assign nandCeN   = pinsReg.ceN;
  assign nandWpN   = 1'b1;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_confirm_needs_data;
    reqFire && reqIn.op == OP_CONFIRM && !loadedReg |=> respValid && respOut.refused;
  endproperty
  a_confirm_needs_data: assert property (p_confirm_needs_data) else $error("confirm sent without data");
  property p_otp_no_random;
    reqFire && otpModeReg && reqIn.op == OP_RANDOM_IN |=> stateReg == ST_DONE ##1 stateReg == ST_IDLE;
  endproperty
  a_otp_no_random: assert property (p_otp_no_random) else $error("random input issued in otp mode");
  property p_busy_quiet;
    stateReg == ST_RB ##1 stateReg == ST_RB |-> !nandCle && !nandAle && nandWeN;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("pin activity while device busy");
  property p_erase_page_zero;
    stateReg == ST_ADDR && reqReg.op == OP_ERASE && beatReg == 12'h001 && !phReg
      |=> nandAle && nandIoOut[PAGE_BITS-1:0] == '0;
  endproperty
  a_erase_page_zero: assert property (p_erase_page_zero) else $error("erase address carries page bits");
  property p_otp_col_zero;
    stateReg == ST_ADDR && otpModeReg && !info.feat && addrSel != 2'h2 && !phReg |=> nandIoOut == 8'h00;
  endproperty
  a_otp_col_zero: assert property (p_otp_col_zero) else $error("nonzero otp column byte");
  property p_program_order;
    stateReg == ST_CMD && reqReg.op == OP_PROGRAM && beatEnd && beatReg != 12'h000 |=> stateReg == ST_ADDR;
  endproperty
  a_program_order: assert property (p_program_order) else $error("program command not followed by address");
  property p_ready_to_status;
    stateReg == ST_RB && rbSync2 |=> stateReg == ST_STAT_CMD ##[1:8] nandCle && !nandWeN;
  endproperty
  a_ready_to_status: assert property (p_ready_to_status) else $error("status not read after ready");
  property p_done_on_cache_ready;
    stateReg == ST_STAT_RD && beatEnd && beatReg != 12'h000 && statusReg[status_cache_ready_bit] |=> respValid;
  endproperty
  a_done_on_cache_ready: assert property (p_done_on_cache_ready) else $error("ready status not answered");
  property p_otp_locked;
    reqFire && otpModeReg && otpLockedReg && reqIn.op == OP_PROGRAM |=> respOut.refused;
  endproperty
  a_otp_locked: assert property (p_otp_locked) else $error("program accepted in locked otp area");

  c_program_done: cover property (respValid && reqReg.op == OP_CONFIRM && !respOut.refused);
  c_cache_done:   cover property (respValid && reqReg.op == OP_CACHE_CONFIRM && !respOut.refused);
  c_erase_done:   cover property (respValid && reqReg.op == OP_ERASE && !respOut.refused);
  c_refused:      cover property (respValid && respOut.refused);
endmodule : nfh_host
`default_nettype wire

// ===== test/nfh_dev_model.sv
// Purpose: behavioural flash device facing the host engine
// Assumes: read cycles after 70h return status; write protect released
// Notes:   busy lasts 20 clocks so the run stays short
`default_nettype none
module nfh_dev_model
  import nfh_pkg::*;
(
  // timing and fault injection
  input  wire logic       clk,
  input  wire logic       failNext,
  // host strobes
  input  wire logic       cle,
  input  wire logic       ale,
  input  wire logic       weN,
  input  wire logic       reN,
  input  wire logic       ceN,
  // data and ready/busy
  input  wire logic [7:0] hostIo,
  output logic [7:0]      devIo,
  output logic            rbN
);
  timeunit 1ns;
  timeprecision 100ps;
  logic        weQ = 1'b1, reQ = 1'b1;
  logic [7:0]  cmd = 8'h00, op = 8'h00, stat = 8'hc0, last = 8'h00, dat = 8'h00;
  logic [15:0] adr = 16'h0000;
  int          nCmd = 0, nData = 0, busy = 0, nRd = 0;
  assign rbN   = (busy == 0);
  // released bus shows the inverse of the last byte, not a stale copy
  // data reads return their strobe index so the bench can follow the byte order
  assign devIo = (reN || ceN) ? ~last : (cmd == CMD_READ_STATUS) ? stat : 8'(nRd);
  always @(posedge clk) begin
    weQ <= weN;
    reQ <= reN;
    if (reN && !reQ && !ceN) nRd <= nRd + 1;
    if (busy > 0) busy <= busy - 1;
    if (busy == 1) stat <= {3'b111, 4'h0, failNext};
    if (weN && !weQ && !ceN) begin
      last <= hostIo;
      if (cle) begin
        cmd <= hostIo;
        nRd <= 0;
        nCmd <= nCmd + 1;
        if (hostIo != CMD_READ_STATUS) op <= hostIo;
        if (hostIo == CMD_SERIAL_IN) nData <= 0;
        if (hostIo inside {CMD_PROG_CONFIRM, CMD_CACHE_PROG, CMD_ERASE_CONFIRM, CMD_COPY_READ}) begin
          busy <= 20;
          stat <= 8'h80;
        end
      end else if (ale) adr <= {hostIo, adr[15:8]};
      else begin
        nData <= nData + 1;
        dat <= hostIo;
        if (cmd == CMD_SET_FEATURE) busy <= 20;
      end
    end
  end
endmodule : nfh_dev_model
`default_nettype wire

// ===== test/testbench.sv
// Purpose: self-checking bench for the flash host engine
// Assumes: device model answers promptly; read stream stalls every other cycle
// Notes:   lengths and columns of the first three programs and the erase row come from a fixed-seed shift register
`default_nettype none
module testbench
  import nfh_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, sys_rst = 1, reqValid = 0, wrValid = 0, failNext = 0, rdReady = 1;
  logic reqReady, respValid, wrReady, nandCle, nandAle, nandWeN, nandReN, nandCeN, nandRbN, rdValid;
  logic [7:0]  wrData = 8'h00, sent = 8'h00, nandIoIn, nandIoOut, rdData;
  logic [15:0] lfsr = 16'h3fcd, row;
  logic [11:0] ln;
  nfhReq_t     reqIn = '0;
  nfhResp_t    respOut, resp;
  int errors = 0, num_checks = 0, quota = 0, pushed = 0, rdExp = 0, rdBase = 0, c0;
  initial forever #5 clk = ~clk;
  nfh_host i_dut (.clk, .sys_rst, .reqIn, .reqValid, .reqReady, .respOut, .respValid, .wrData, .wrValid,
    .wrReady, .rdData, .rdValid, .rdReady, .nandIoIn, .nandIoOut, .nandIoOe(), .nandCle,
    .nandAle, .nandWeN, .nandReN, .nandCeN, .nandWpN(), .nandRbN);
  nfh_dev_model i_mdl (.clk, .failNext, .cle(nandCle), .ale(nandAle), .weN(nandWeN), .reN(nandReN),
    .ceN(nandCeN), .hostIo(nandIoOut), .devIo(nandIoIn), .rbN(nandRbN));
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : nxt
  // erase keeps plane and block bits only
  function automatic logic [15:0] eraseRow(input logic [15:0] r);
    return {r[15:6], 6'h00};
  endfunction : eraseRow
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  task automatic req(input nfhOp_t op, input logic [15:0] col, input logic [15:0] r, input logic [11:0] n);
    int k;
    k = 0;
    c0 = i_mdl.nCmd;
    reqIn = '{op: op, col: col, row: r, len: n};
    reqValid = 1'b1;
    while (reqReady !== 1'b1 && k < 100) begin @(posedge clk); #1; k++; end
    @(posedge clk);
    #1 reqValid = 1'b0;
    while (respValid !== 1'b1 && k < 5000) begin @(posedge clk); #1; k++; end
    if (k >= 5000) begin errors++; finish_test(); end
    resp = respOut;
  endtask : req
  // write stream feeder; the buffer may stall it at any edge
  always @(posedge clk) begin
    if (wrValid && wrReady) begin pushed <= pushed + 1; sent <= wrData; lfsr <= nxt(lfsr); end
    #1 wrData = lfsr[7:0];
    wrValid = (pushed < quota);
    rdReady = ~rdReady;
  end
  // a read byte counts at the edge where valid and ready meet
  always @(posedge clk) begin
    #2;
    if (rdValid === 1'b1 && rdReady === 1'b1) begin
      check("read byte", rdData, 8'(rdExp - rdBase));
      rdExp++;
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    #1 sys_rst = 1'b0;
    for (int i = 0; i < 3; i++) begin
      ln = {10'h000, lfsr[1:0]} + 12'h001;
      row = 16'h0140 + 16'(i);
      quota = quota + int'(ln);
      req(OP_PROGRAM, {8'h00, lfsr[15:8]}, row, ln);
      check("program refused", resp.refused, 0);
      check("data count", i_mdl.nData, ln);
      check("last byte", i_mdl.dat, sent);
      check("row", i_mdl.adr, row);
      req(i < 2 ? OP_CACHE_CONFIRM : OP_CONFIRM, '0, '0, '0);
      check("confirm cmd", i_mdl.op, i < 2 ? CMD_CACHE_PROG : CMD_PROG_CONFIRM);
      check("ready bit", resp.status[status_cache_ready_bit], 1);
      check("status cmd", i_mdl.cmd, CMD_READ_STATUS);
    end
    $display("test program done");
    req(OP_PROGRAM, '0, 16'h0140, 12'h001);
    check("backward page", {resp.refused, 8'(i_mdl.nCmd - c0)}, 9'h100);
    req(OP_CONFIRM, '0, '0, '0);
    check("empty confirm", {resp.refused, 8'(i_mdl.nCmd - c0)}, 9'h100);
    $display("test refusals done");
    quota = quota + 2;
    req(OP_PROGRAM, '0, 16'h0143, 12'h002);
    quota = quota + 2;
    req(OP_RANDOM_IN, 16'h0123, '0, 12'h002);
    check("random column", i_mdl.adr, 16'h0123);
    check("random count", i_mdl.nData, 4);
    check("random last byte", i_mdl.dat, sent);
    req(OP_CONFIRM, '0, '0, '0);
    check("random confirm", i_mdl.op, CMD_PROG_CONFIRM);
    $display("test random input done");
    req(OP_COPY_READ, '0, 16'h0200, '0);
    check("copy source", {i_mdl.op, i_mdl.adr}, {CMD_COPY_READ, 16'h0200});
    rdBase = rdExp;
    req(OP_READ_OUT, '0, '0, 12'h003);
    check("copy bytes out", rdExp - rdBase, 3);
    req(OP_COPY_PROGRAM, '0, 16'h0240, '0);
    check("copy destination", {i_mdl.op, i_mdl.adr}, {CMD_RANDOM_IN, 16'h0240});
    req(OP_CONFIRM, '0, '0, '0);
    check("copy confirm", {resp.refused, i_mdl.op}, {1'b0, CMD_PROG_CONFIRM});
    $display("test copy-back done");
    failNext = 1'b1;
    row = lfsr;
    req(OP_ERASE, '0, row, '0);
    check("erase row", i_mdl.adr, eraseRow(row));
    check("erase fail", resp.fail, 1);
    failNext = 1'b0;
    $display("test erase done");
    req(OP_OTP_ENTER, '0, '0, '0);
    check("otp enter", i_mdl.dat, FEAT_OTP_ENTER);
    req(OP_RANDOM_IN, '0, '0, 12'h001);
    check("otp random in", resp.refused, 1);
    quota = quota + 1;
    req(OP_PROGRAM, 16'h00a5, 16'h7705, 12'h001);
    check("otp row", i_mdl.adr, 16'h0005);
    req(OP_CONFIRM, '0, '0, '0);
    req(OP_PROGRAM, '0, 16'h0003, 12'h001);
    check("otp backward", resp.refused, 1);
    req(OP_OTP_PROTECT, '0, '0, '0);
    check("otp protect", i_mdl.dat, FEAT_OTP_PROTECT);
    req(OP_PROGRAM, '0, 16'h0010, 12'h001);
    check("otp locked", {resp.refused, 8'(i_mdl.nCmd - c0)}, 9'h100);
    req(OP_OTP_EXIT, '0, '0, '0);
    check("otp exit", i_mdl.dat, FEAT_OTP_EXIT);
    $display("test otp done");
    finish_test();
  end
endmodule : testbench
`default_nettype wire
